/* inc/ebi_defines.svh */
// Offsets, field positions, reset values and clock counts of the
// external bus controller. Included by bare name; definitions only.
`ifndef EBI_DEFINES_SVH
`define EBI_DEFINES_SVH

// ****************************************************************
// Register word indices (byte address = index * 4)
// ****************************************************************
`define EBI_MODE_IDX 30'h0fffffbe
`define EBI_BWC_IDX 30'h0fffffc0
`define EBI_DWC_IDX 30'h0fffffc1
`define EBI_STAT_IDX 30'h0fffffc2

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define EBI_MODE_SEP_BIT 0
`define EBI_MODE_RST 1'b0
`define EBI_BWC_RST 16'h0055
`define EBI_BWC_MASK 16'h0055
`define EBI_DWC_RST 16'h7777
`define EBI_DWC_MASK 16'h7777

// ****************************************************************
// Address map (26-bit linear space)
// ****************************************************************
`define EBI_EXT_BASE 26'h0100000
`define EBI_CS1_BASE 26'h0200000
`define EBI_CS2_BASE 26'h0400000
`define EBI_CS3_BASE 26'h0800000
`define EBI_CS_TOP 26'h1000000
`define EBI_SM_CS0_END 26'h010ffff
`define EBI_SM_CS1_END 26'h020ffff
`define EBI_MID_CS1_END 26'h03fffff
`define EBI_RAM_BASE 26'h3ff0000
`define EBI_PERI_BASE 26'h3fff000

// ****************************************************************
// Clocks per internal access
// ****************************************************************
`define EBI_ROM_SEQ_CLKS 4'h1
`define EBI_ROM_BR_CLKS 4'h2
`define EBI_ROM_OPD_CLKS 4'h3
`define EBI_RAM_FETCH_CLKS 4'h1
`define EBI_RAM_OPD_CLKS 4'h1
`define EBI_PERI_CLKS 4'h3

`endif

/* inc/ebi_pkg.sv */
// Types shared by the external bus controller and its decoder.
// Assumes the defines header is available to the including files.
package ebi_pkg;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [2:0] {EBI_TGT_NONE, EBI_TGT_ROM, EBI_TGT_RAM, EBI_TGT_PERI, EBI_TGT_EXT} ebi_tgt_t;
  typedef enum logic [1:0] {EBI_KIND_SEQ, EBI_KIND_BRANCH, EBI_KIND_OPND} ebi_kind_t;
  typedef enum logic [1:0] {EBI_SZ_BYTE, EBI_SZ_HALF, EBI_SZ_WORD} ebi_sz_t;
  typedef enum logic [1:0] {EBI_CFG_SMALL, EBI_CFG_MID, EBI_CFG_FULL} ebi_cfg_t;
  typedef enum logic [2:0] {EBI_ST_IDLE, EBI_ST_INT, EBI_ST_T1, EBI_ST_T2, EBI_ST_TW, EBI_ST_T3} ebi_st_t;

  // ****************************************************************
  // Whole state of the controller
  // ****************************************************************
  typedef struct packed {
    ebi_st_t st;
    logic mode_sep;
    logic [15:0] bwc;
    logic [15:0] dwc;
    logic wr_pend;
    logic [29:0] wr_idx;
    logic [3:0] wr_lanes;
    logic rd_pend;
    logic [29:0] rd_idx;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    ebi_tgt_t tgt;
    ebi_sz_t size;
    logic write;
    logic [25:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0] area;
    logic bus16;
    logic [2:0] waits;
    logic [2:0] part;
    logic [2:0] parts;
    logic [3:0] wcnt;
    logic [7:0] clk_cnt;
    logic [7:0] last_clks;
    ebi_tgt_t last_tgt;
    logic [15:0] ad_o;
    logic ad_oe;
    logic [23:0] addr_o;
    logic [3:0] cs_n;
    logic rd_n;
    logic [1:0] wr_n;
    logic astb;
    logic done;
    logic busy;
    logic [31:0] cpu_rdata;
  } ebi_core_t;

endpackage : ebi_pkg

/* inc/ebi_dec_if.sv */
// Carrier between the controller and its address decoder.
// Assumes ebi_pkg is compiled first.
`timescale 1ns/1ps
interface ebi_dec_if;
  import ebi_pkg::*;
  logic [25:0] addr;
  ebi_sz_t size;
  ebi_kind_t kind;
  logic [15:0] bwc;
  logic [15:0] dwc;
  ebi_tgt_t tgt;
  logic [1:0] area;
  logic bus16;
  logic [2:0] waits;
  logic [2:0] parts;
  logic [3:0] int_clks;
  modport ctl (output addr, size, kind, bwc, dwc, input tgt, area, bus16, waits, parts, int_clks);
  modport dec (input addr, size, kind, bwc, dwc, output tgt, area, bus16, waits, parts, int_clks);
endinterface : ebi_dec_if

/* hw/ebi_decode.sv */
// Address decoder: target, chip-select area, width, waits and clocks.
// Assumes a combinational caller that samples the result at take time.
`timescale 1ns/1ps
`include "ebi_defines.svh"
module ebi_decode #(
  parameter ebi_pkg::ebi_cfg_t VARIANT = ebi_pkg::EBI_CFG_FULL
) (
  // Decode request and result
  ebi_dec_if.dec d
);
  import ebi_pkg::*;

  // Bus cycles needed for one access on a given width
  function automatic logic [2:0] ebi_parts(input ebi_sz_t sz, input logic b16);
    logic [2:0] p;
    p = 3'h1;
    case (sz)
      EBI_SZ_HALF: p = b16 ? 3'h1 : 3'h2;
      EBI_SZ_WORD: p = b16 ? 3'h2 : 3'h4;
      default: p = 3'h1;
    endcase
    return p;
  endfunction : ebi_parts

  // ****************************************************************
  // Target and area decode
  // ****************************************************************
  logic hit;
  logic [1:0] ar;

  // Fixed chip-select windows per configuration
  always_comb
  begin
    hit = 1'b0;
    ar = 2'h0;
    case (VARIANT)
      EBI_CFG_SMALL:
      begin
        if (d.addr >= `EBI_EXT_BASE && d.addr <= `EBI_SM_CS0_END) hit = 1'b1;
        else if (d.addr >= `EBI_CS1_BASE && d.addr <= `EBI_SM_CS1_END)
        begin
          hit = 1'b1;
          ar = 2'h1;
        end
      end
      EBI_CFG_MID:
      begin
        hit = (d.addr >= `EBI_EXT_BASE) && (d.addr <= `EBI_MID_CS1_END);
        ar = (d.addr >= `EBI_CS1_BASE) ? 2'h1 : 2'h0;
      end
      default:
      begin
        hit = (d.addr >= `EBI_EXT_BASE) && (d.addr < `EBI_CS_TOP);
        if (d.addr >= `EBI_CS3_BASE) ar = 2'h3;
        else if (d.addr >= `EBI_CS2_BASE) ar = 2'h2;
        else if (d.addr >= `EBI_CS1_BASE) ar = 2'h1;
        else ar = 2'h0;
      end
    endcase
  end

  // Target, width, waits and internal clock count
  always_comb
  begin
    d.area = ar;
    d.bus16 = 1'b1;
    d.waits = 3'h0;
    d.int_clks = 4'h1;
    if (d.addr < `EBI_EXT_BASE)
    begin
      d.tgt = EBI_TGT_ROM;
      case (d.kind)
        EBI_KIND_SEQ: d.int_clks = `EBI_ROM_SEQ_CLKS;
        EBI_KIND_BRANCH: d.int_clks = `EBI_ROM_BR_CLKS;
        default: d.int_clks = `EBI_ROM_OPD_CLKS;
      endcase
    end
    else if (hit)
    begin
      d.tgt = EBI_TGT_EXT;
      d.bus16 = d.bwc[{ar, 1'b0}];
      d.waits = d.dwc[{ar, 2'b00} +: 3];
    end
    else if (d.addr >= `EBI_PERI_BASE)
    begin
      d.tgt = EBI_TGT_PERI;
      d.int_clks = 4'(`EBI_PERI_CLKS * ebi_parts(d.size, 1'b1));
    end
    else if (d.addr >= `EBI_RAM_BASE)
    begin
      d.tgt = EBI_TGT_RAM;
      d.int_clks = (d.kind == EBI_KIND_OPND) ? `EBI_RAM_OPD_CLKS : `EBI_RAM_FETCH_CLKS;
    end
    else
    begin
      d.tgt = EBI_TGT_NONE;
    end
    d.parts = ebi_parts(d.size, d.bus16);
  end

endmodule : ebi_decode

/* hw/ebi_top.sv */
// External bus controller: chip-select decode, bus mode, widths, waits.
// Assumes one AHB-Lite master and a CPU port that holds a request
// until the done pulse; pin inputs are synchronous to hclk.
`timescale 1ns/1ps
`include "ebi_defines.svh"
module ebi_top #(
  parameter ebi_pkg::ebi_cfg_t VARIANT = ebi_pkg::EBI_CFG_FULL
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // CPU access port
  input wire logic cpu_req,
  input wire logic [25:0] cpu_addr,
  input wire logic cpu_write,
  input wire ebi_pkg::ebi_sz_t cpu_size,
  input wire ebi_pkg::ebi_kind_t cpu_kind,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_done,
  output logic cpu_busy,
  output logic [31:0] cpu_rdata,
  // External memory pins
  input wire logic [15:0] ext_ad_i,
  output logic [15:0] ext_ad_o,
  output logic ext_ad_oe,
  output logic [23:0] ext_addr_o,
  output logic [3:0] chip_select_line_n,
  output logic ext_rd_n,
  output logic [1:0] ext_wr_n,
  output logic ext_astb,
  input wire logic ext_wait_n
);
  import ebi_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Byte lanes of an AHB transfer
  function automatic logic [3:0] ebi_ahb_lanes(input logic [1:0] a, input logic [2:0] sz);
    logic [3:0] l;
    l = 4'hf;
    case (sz)
      3'h0: l = 4'(4'h1 << a);
      3'h1: l = a[1] ? 4'hc : 4'h3;
      default: l = 4'hf;
    endcase
    return l;
  endfunction : ebi_ahb_lanes

  // Merge the low two lanes of a write into a 16-bit register
  function automatic logic [15:0] ebi_merge16(input logic [15:0] old, input logic [31:0] wd,
                                              input logic [1:0] ln, input logic [15:0] msk);
    logic [15:0] v;
    v = old;
    if (ln[0]) v[7:0] = wd[7:0];
    if (ln[1]) v[15:8] = wd[15:8];
    return v & msk;
  endfunction : ebi_merge16

  // Write data and strobes of the current portion
  function automatic logic [17:0] ebi_wlane(input ebi_core_t s);
    logic [31:0] sh;
    logic [17:0] r;
    sh = s.bus16 ? (s.wdata >> {s.part, 4'h0}) : (s.wdata >> {s.part, 3'h0});
    if (!s.bus16) r = {8'h00, sh[7:0], 2'b10};
    else if (s.size == EBI_SZ_BYTE && s.addr[0]) r = {sh[7:0], 8'h00, 2'b01};
    else if (s.size == EBI_SZ_BYTE) r = {8'h00, sh[7:0], 2'b10};
    else r = {sh[15:0], 2'b00};
    return r;
  endfunction : ebi_wlane

  // Place read lane data of the current portion
  function automatic logic [31:0] ebi_rcap(input ebi_core_t s, input logic [15:0] ad);
    logic [31:0] r;
    r = s.rdata;
    if (!s.bus16) r = r | (32'(ad[7:0]) << {s.part, 3'h0});
    else if (s.size == EBI_SZ_BYTE) r = 32'(s.addr[0] ? ad[15:8] : ad[7:0]);
    else r = r | (32'(ad) << {s.part, 4'h0});
    return r;
  endfunction : ebi_rcap

  // Drive pins for the first state of a bus cycle
  function automatic ebi_core_t ebi_start(input ebi_core_t s, input logic sep);
    ebi_core_t r;
    logic [17:0] wl;
    r = s;
    wl = ebi_wlane(s);
    r.st = EBI_ST_T1;
    r.cs_n = ~(4'(4'h1 << s.area));
    r.addr_o = s.addr[23:0];
    r.astb = ~sep;
    r.wcnt = {1'b0, s.waits};
    if (sep)
    begin
      r.rd_n = s.write;
      r.wr_n = s.write ? wl[1:0] : 2'b11;
      r.ad_o = wl[17:2];
      r.ad_oe = s.write;
    end
    else
    begin
      r.ad_o = s.addr[15:0];
      r.ad_oe = 1'b1;
      r.rd_n = 1'b1; // Strobes idle while AD carries the address
      r.wr_n = 2'b11;
    end
    return r;
  endfunction : ebi_start

  // ****************************************************************
  // State, decoder and derived terms
  // ****************************************************************
  ebi_core_t s_r;
  ebi_core_t s_nxt;
  ebi_dec_if dif ();
  logic sep;
  logic take;
  logic wneed;
  logic final_st;
  logic [17:0] wl;
  logic [31:0] rcap;

  localparam ebi_core_t EBI_RST = '{st: EBI_ST_IDLE, mode_sep: `EBI_MODE_RST, bwc: `EBI_BWC_RST,
                                   dwc: `EBI_DWC_RST, hready: 1'b1, tgt: EBI_TGT_NONE,
                                   size: EBI_SZ_BYTE, last_tgt: EBI_TGT_NONE, cs_n: 4'hf,
                                   rd_n: 1'b1, wr_n: 2'b11, default: '0};

  ebi_decode #(
    .VARIANT(VARIANT)
  ) u_dec (
    .d(dif.dec)
  );

  // Decoder fed from the incoming request and live config
  assign dif.addr = cpu_addr;
  assign dif.size = cpu_size;
  assign dif.kind = cpu_kind;
  assign dif.bwc = s_r.bwc;
  assign dif.dwc = s_r.dwc;

  // Mode, acceptance and wait terms
  assign sep = (VARIANT != EBI_CFG_SMALL) && s_r.mode_sep;
  assign take = (s_r.st == EBI_ST_IDLE) && cpu_req && !s_r.done;
  assign wneed = (s_r.wcnt != 4'h0) || !ext_wait_n;
  assign final_st = sep ? (s_r.st == EBI_ST_T2) : (s_r.st == EBI_ST_T3);
  assign wl = ebi_wlane(s_r);
  assign rcap = ebi_rcap(s_r, ext_ad_i);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Register bus, access sequencer and pins
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.hresp = 1'b0;

    // Write data phase commits the earlier address phase
    if (s_r.wr_pend)
    begin
      if (s_r.wr_idx == `EBI_MODE_IDX && s_r.wr_lanes[0] && VARIANT != EBI_CFG_SMALL)
        s_nxt.mode_sep = hwdata[`EBI_MODE_SEP_BIT];
      else if (s_r.wr_idx == `EBI_BWC_IDX)
        s_nxt.bwc = ebi_merge16(s_r.bwc, hwdata, s_r.wr_lanes[1:0], `EBI_BWC_MASK);
      else if (s_r.wr_idx == `EBI_DWC_IDX)
        s_nxt.dwc = ebi_merge16(s_r.dwc, hwdata, s_r.wr_lanes[1:0], `EBI_DWC_MASK);
    end
    s_nxt.wr_pend = 1'b0;

    // Read answer one cycle after its address phase
    if (s_r.rd_pend)
    begin
      s_nxt.rd_pend = 1'b0;
      s_nxt.hready = 1'b1;
      case (s_r.rd_idx)
        `EBI_MODE_IDX: s_nxt.hrdata = {31'h0, sep};
        `EBI_BWC_IDX: s_nxt.hrdata = {16'h0, s_r.bwc};
        `EBI_DWC_IDX: s_nxt.hrdata = {16'h0, s_r.dwc};
        `EBI_STAT_IDX: s_nxt.hrdata = {16'h0, s_r.last_clks, 4'h0, s_r.last_tgt, s_r.busy};
        default: s_nxt.hrdata = 32'h0;
      endcase
    end

    // New address phase
    if (hsel && htrans[1] && hready)
    begin
      if (hwrite)
      begin
        s_nxt.wr_pend = 1'b1;
        s_nxt.wr_idx = haddr[31:2];
        s_nxt.wr_lanes = ebi_ahb_lanes(haddr[1:0], hsize);
      end
      else
      begin
        s_nxt.rd_pend = 1'b1;
        s_nxt.rd_idx = haddr[31:2];
        s_nxt.hready = 1'b0;
      end
    end

    // Clock count of the access in progress
    if (s_r.st != EBI_ST_IDLE && s_r.clk_cnt != 8'hff)
      s_nxt.clk_cnt = s_r.clk_cnt + 8'h01;

    case (s_r.st)
      EBI_ST_IDLE:
      begin
        if (take)
        begin
          s_nxt.busy = 1'b1;
          s_nxt.clk_cnt = 8'h01;
          s_nxt.tgt = dif.tgt;
          s_nxt.size = cpu_size;
          s_nxt.write = cpu_write;
          s_nxt.addr = cpu_addr;
          s_nxt.wdata = cpu_wdata;
          s_nxt.rdata = 32'h0;
          s_nxt.area = dif.area;
          s_nxt.bus16 = dif.bus16;
          s_nxt.waits = dif.waits;
          s_nxt.part = 3'h0;
          s_nxt.parts = dif.parts;
          if (dif.tgt == EBI_TGT_EXT)
            s_nxt = ebi_start(s_nxt, sep);
          else
          begin
            s_nxt.st = EBI_ST_INT;
            s_nxt.wcnt = dif.int_clks - 4'h1;
            if (dif.tgt == EBI_TGT_PERI)
              s_nxt.addr_o = cpu_addr[23:0];
          end
        end
      end
      EBI_ST_INT:
      begin
        // Data bus floated and strobes idle throughout
        if (s_r.wcnt == 4'h0)
        begin
          s_nxt.st = EBI_ST_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.last_clks = s_r.clk_cnt;
          s_nxt.last_tgt = s_r.tgt;
          s_nxt.cpu_rdata = 32'h0;
        end
        else
          s_nxt.wcnt = s_r.wcnt - 4'h1;
      end
      EBI_ST_T1:
      begin
        if (sep)
        begin
          s_nxt.st = wneed ? EBI_ST_TW : EBI_ST_T2;
          if (s_r.wcnt != 4'h0) s_nxt.wcnt = s_r.wcnt - 4'h1;
        end
        else
        begin
          s_nxt.st = EBI_ST_T2;
          s_nxt.astb = 1'b0;
          s_nxt.rd_n = s_r.write;
          s_nxt.wr_n = s_r.write ? wl[1:0] : 2'b11;
          s_nxt.ad_o = wl[17:2];
          s_nxt.ad_oe = s_r.write;
        end
      end
      EBI_ST_TW:
      begin
        if (!wneed)
          s_nxt.st = sep ? EBI_ST_T2 : EBI_ST_T3;
        else if (s_r.wcnt != 4'h0)
          s_nxt.wcnt = s_r.wcnt - 4'h1;
      end
      EBI_ST_T2,
      EBI_ST_T3:
      begin
        if (!final_st)
        begin
          s_nxt.st = wneed ? EBI_ST_TW : EBI_ST_T3;
          if (s_r.wcnt != 4'h0) s_nxt.wcnt = s_r.wcnt - 4'h1;
        end
        else
        begin
          if (!s_r.write) s_nxt.rdata = rcap;
          if (s_r.part + 3'h1 < s_r.parts)
          begin
            s_nxt.part = s_r.part + 3'h1;
            s_nxt.addr = s_r.addr + (s_r.bus16 ? 26'h2 : 26'h1);
            s_nxt = ebi_start(s_nxt, sep);
          end
          else
          begin
            s_nxt.st = EBI_ST_IDLE;
            s_nxt.cs_n = 4'hf;
            s_nxt.rd_n = 1'b1;
            s_nxt.wr_n = 2'b11;
            s_nxt.astb = 1'b0;
            s_nxt.ad_oe = 1'b0;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.last_clks = s_r.clk_cnt;
            s_nxt.last_tgt = s_r.tgt;
            s_nxt.cpu_rdata = s_r.write ? 32'h0 : rcap;
          end
        end
      end
      default:
      begin
        s_nxt.st = EBI_ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register and outputs
  // ****************************************************************

  // Single register of the whole state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= EBI_RST;
    else
      s_r <= s_nxt;
  end

  // Outputs straight from the state register
  assign hreadyout = s_r.hready;
  assign hrdata = s_r.hrdata;
  assign hresp = s_r.hresp;
  assign cpu_done = s_r.done;
  assign cpu_busy = s_r.busy;
  assign cpu_rdata = s_r.cpu_rdata;
  assign ext_ad_o = s_r.ad_o;
  assign ext_ad_oe = s_r.ad_oe;
  assign ext_addr_o = s_r.addr_o;
  assign chip_select_line_n = s_r.cs_n;
  assign ext_rd_n = s_r.rd_n;
  assign ext_wr_n = s_r.wr_n;
  assign ext_astb = s_r.astb;

endmodule : ebi_top

/* bench/ebi_mem_model.sv */
// External memory model answering reads with address-derived bytes.
// Assumes pins of ebi_top; wait is stretched only while slow is high.
`timescale 1ns/1ps
module ebi_mem_model (
  // Clock and control
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  // Memory pins
  input wire logic [3:0] chip_select_line_n,
  input wire logic ext_rd_n,
  input wire logic [23:0] ext_addr_o,
  output logic [15:0] ext_ad_i,
  output logic ext_wait_n
);
  logic [15:0] last_r;
  logic [2:0] wcnt_r;
  logic on;
  // ****************************************************************
  // Read data, released bus toggles
  // ****************************************************************
  assign on = chip_select_line_n != 4'hf && !ext_rd_n;
  assign ext_ad_i = on ? {(ext_addr_o[7:0] | 8'h01) ^ 8'ha5, ext_addr_o[7:0] ^ 8'ha5} : ~last_r;
  // External wait for three cycles of each select
  assign ext_wait_n = !(slow && chip_select_line_n != 4'hf && wcnt_r < 3'h3);
  // History of bus and select length
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_r <= 16'h0000;
      wcnt_r <= 3'h0;
    end
    else
    begin
      last_r <= ext_ad_i;
      wcnt_r <= (chip_select_line_n == 4'hf) ? 3'h0 : wcnt_r + ((wcnt_r < 3'h7) ? 3'h1 : 3'h0);
    end
  end
endmodule : ebi_mem_model

/* bench/ebi_top_monitor.sv */
// Port checker of the external bus controller.
// Assumes it is bound into ebi_top and sees its ports only.
`timescale 1ns/1ps
module ebi_top_monitor (
  // Clock, reset and register bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  // CPU port
  input wire logic cpu_req,
  input wire logic [25:0] cpu_addr,
  input wire ebi_pkg::ebi_kind_t cpu_kind,
  input wire logic cpu_done,
  input wire logic cpu_busy,
  // Memory pins
  input wire logic ext_ad_oe,
  input wire logic [23:0] ext_addr_o,
  input wire logic [3:0] chip_select_line_n,
  input wire logic ext_rd_n,
  input wire logic [1:0] ext_wr_n,
  input wire logic ext_astb
);
  import ebi_pkg::*;
  logic take, rom, ram, peri;
  // ****************************************************************
  // Access decode
  // ****************************************************************
  assign take = cpu_req && !cpu_busy && !cpu_done;
  assign rom = cpu_addr < 26'h0100000;
  assign ram = cpu_addr >= 26'h3ff0000 && cpu_addr < 26'h3fff000;
  assign peri = cpu_addr >= 26'h3fff000;
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Pin behaviour per target
  a_rom_pins_quiet: assert property (cpu_busy && rom |-> chip_select_line_n == 4'hf && ext_rd_n &&
    ext_wr_n == 2'b11 && !ext_ad_oe && !ext_astb) else $error("pins active on internal access");
  a_peri_addr_out: assert property (cpu_busy && $past(cpu_busy) && peri |->
    ext_addr_o[23:2] == cpu_addr[23:2] && chip_select_line_n == 4'hf && !ext_ad_oe) else $error("bad peri pins");
  a_area3_select: assert property (!ext_rd_n && cpu_addr >= 26'h0800000 && cpu_addr < 26'h1000000 |->
    chip_select_line_n == 4'h7) else $error("wrong select for top area");
  a_astb_one_cycle: assert property (ext_astb |-> (ext_ad_oe && chip_select_line_n != 4'hf && ext_rd_n &&
    ext_wr_n == 2'b11) ##1 !ext_astb) else $error("address strobe malformed");
  // Internal clock counts
  a_rom_seq_clks: assert property (take && rom && cpu_kind == EBI_KIND_SEQ |-> ##2 cpu_done)
    else $error("rom sequential fetch time");
  a_rom_opnd_clks: assert property (take && rom && cpu_kind == EBI_KIND_OPND |-> !cpu_done [*4] ##1 cpu_done)
    else $error("rom operand time");
  a_ram_clks: assert property (take && ram |-> ##2 cpu_done)
    else $error("ram access time");
  // Register read wait
  a_reg_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("register read answer timing");
endmodule : ebi_top_monitor
bind ebi_top ebi_top_monitor i_ebi_top_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
  .cpu_kind(cpu_kind), .cpu_done(cpu_done), .cpu_busy(cpu_busy), .ext_ad_oe(ext_ad_oe), .ext_addr_o(ext_addr_o),
  .chip_select_line_n(chip_select_line_n), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_astb(ext_astb));

/* bench/ebi_top_tb.sv */
// Self-checking bench of the external bus controller.
// Assumes ebi_pkg, the decoder, the top and the memory model compiled.
`timescale 1ns/1ps
`include "ebi_defines.svh"
module ebi_top_tb;
  import ebi_pkg::*;
  typedef struct packed {logic [25:0] a; ebi_sz_t s; ebi_kind_t k; logic w; logic m; logic [7:0] n; logic [2:0] t;}
    ebi_row_t;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cpu_req = 1'b0, cpu_write = 1'b0, slow = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, cpu_wdata = 32'h0, hrdata, cpu_rdata, d, e;
  logic [1:0] htrans = 2'h0, ext_wr_n;
  logic [25:0] cpu_addr = 26'h0;
  ebi_sz_t cpu_size = EBI_SZ_BYTE;
  ebi_kind_t cpu_kind = EBI_KIND_SEQ;
  logic hreadyout, hresp, cpu_done, cpu_busy, ext_ad_oe, ext_rd_n, ext_astb, ext_wait_n;
  logic [15:0] ext_ad_i, ext_ad_o;
  logic [23:0] ext_addr_o;
  logic [3:0] cs_n;
  int n_checks = 0, n_mismatch = 0;
  ebi_row_t rows [15] = '{
    '{26'h0000100, EBI_SZ_WORD, EBI_KIND_SEQ, 1'b0, 1'b0, 8'h01, 3'h1},
    '{26'h0000100, EBI_SZ_WORD, EBI_KIND_BRANCH, 1'b0, 1'b0, 8'h02, 3'h1},
    '{26'h0000100, EBI_SZ_WORD, EBI_KIND_OPND, 1'b0, 1'b0, 8'h03, 3'h1},
    '{26'h3ff0010, EBI_SZ_WORD, EBI_KIND_SEQ, 1'b0, 1'b0, 8'h01, 3'h2},
    '{26'h3ff0010, EBI_SZ_WORD, EBI_KIND_OPND, 1'b0, 1'b0, 8'h01, 3'h2},
    '{26'h3fff010, EBI_SZ_HALF, EBI_KIND_OPND, 1'b0, 1'b0, 8'h03, 3'h3},
    '{26'h3fff010, EBI_SZ_WORD, EBI_KIND_OPND, 1'b0, 1'b0, 8'h06, 3'h3},
    '{26'h1000000, EBI_SZ_BYTE, EBI_KIND_OPND, 1'b0, 1'b0, 8'h01, 3'h0},
    '{26'h0100002, EBI_SZ_HALF, EBI_KIND_OPND, 1'b0, 1'b0, 8'h03, 3'h4},
    '{26'h0200004, EBI_SZ_WORD, EBI_KIND_OPND, 1'b0, 1'b0, 8'h10, 3'h4},
    '{26'h0400008, EBI_SZ_WORD, EBI_KIND_OPND, 1'b0, 1'b0, 8'h0a, 3'h4},
    '{26'h0800003, EBI_SZ_BYTE, EBI_KIND_OPND, 1'b0, 1'b0, 8'h03, 3'h4},
    '{26'h0100004, EBI_SZ_WORD, EBI_KIND_OPND, 1'b0, 1'b1, 8'h04, 3'h4},
    '{26'h0200006, EBI_SZ_HALF, EBI_KIND_OPND, 1'b0, 1'b1, 8'h06, 3'h4},
    '{26'h0100001, EBI_SZ_BYTE, EBI_KIND_OPND, 1'b1, 1'b1, 8'h02, 3'h4}};
  // ****************************************************************
  // Clock, design and far side
  // ****************************************************************
  always #25 hclk = ~hclk;
  ebi_top i_ebi_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_write(cpu_write), .cpu_size(cpu_size), .cpu_kind(cpu_kind),
    .cpu_wdata(cpu_wdata), .cpu_done(cpu_done), .cpu_busy(cpu_busy), .cpu_rdata(cpu_rdata), .ext_ad_i(ext_ad_i),
    .ext_ad_o(ext_ad_o), .ext_ad_oe(ext_ad_oe), .ext_addr_o(ext_addr_o), .chip_select_line_n(cs_n),
    .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_astb(ext_astb), .ext_wait_n(ext_wait_n));
  ebi_mem_model i_ebi_mem_model (.hclk(hclk), .hresetn(hresetn), .slow(slow), .chip_select_line_n(cs_n),
    .ext_rd_n(ext_rd_n), .ext_addr_o(ext_addr_o), .ext_ad_i(ext_ad_i), .ext_wait_n(ext_wait_n));
  // Verdict and end of run
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for ready (0) or done (1)
  task automatic wait_hi(input bit sel);
    int i;
    i = 0;
    @(posedge hclk);
    while ((sel ? cpu_done : hreadyout) !== 1'b1 && i < 300)
    begin
      i++;
      @(posedge hclk);
    end
    if (i == 300)
    begin
      n_mismatch++;
      $display("unexpected at %0t: handshake timeout", $time);
      wrap_up();
    end
  endtask : wait_hi
  // Single AHB-Lite word transfer
  task automatic ahb(input logic w, input logic [29:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {idx, 2'b00};
    wait_hi(1'b0);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_hi(1'b0);
    rd = hrdata;
  endtask : ahb
  // CPU access held until done
  task automatic cpu(input ebi_row_t r, output logic [31:0] rd);
    @(posedge hclk);
    cpu_req <= 1'b1;
    cpu_addr <= r.a;
    cpu_write <= r.w;
    cpu_size <= r.s;
    cpu_kind <= r.k;
    cpu_wdata <= 32'h5a5a5a5a;
    wait_hi(1'b1);
    rd = cpu_rdata;
    cpu_req <= 1'b0;
  endtask : cpu
  // Little endian bytes the model returns
  function automatic logic [31:0] exp_rd(input logic [25:0] a, input ebi_sz_t s);
    logic [31:0] v;
    for (int k = 0; k < 4; k++)
      v[k*8+:8] = (a[7:0] + 8'(k)) ^ 8'ha5;
    return (s == EBI_SZ_BYTE) ? {24'h0, v[7:0]} : (s == EBI_SZ_HALF) ? {16'h0, v[15:0]} : v;
  endfunction : exp_rd
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `EBI_MODE_IDX, 32'h0, d);
    chk(d, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    ahb(1'b0, `EBI_BWC_IDX, 32'h0, d);
    chk(d, 32'h55);
    ahb(1'b0, `EBI_DWC_IDX, 32'h0, d);
    chk(d, 32'h7777);
    ahb(1'b1, `EBI_MODE_IDX, 32'hffffffff, d);
    ahb(1'b0, `EBI_MODE_IDX, 32'h0, d);
    chk(d, 32'h1);
    ahb(1'b1, 30'h0fffffd0, 32'hffffffff, d);
    ahb(1'b0, 30'h0fffffd0, 32'h0, d);
    chk(d, 32'h0);
    ahb(1'b1, `EBI_BWC_IDX, 32'h0011, d);
    ahb(1'b1, `EBI_DWC_IDX, 32'h0210, d);
    $display("test registers done");
    foreach (rows[i])
    begin
      ahb(1'b1, `EBI_MODE_IDX, {31'h0, rows[i].m}, d);
      cpu(rows[i], d);
      chk(d, (rows[i].t == 3'h4 && !rows[i].w) ? exp_rd(rows[i].a, rows[i].s) : 32'h0);
      ahb(1'b0, `EBI_STAT_IDX, 32'h0, d);
      chk({24'h0, d[15:8]}, {24'h0, rows[i].n});
      chk({29'h0, d[3:1]}, {29'h0, rows[i].t});
    end
    $display("test table done");
    slow <= 1'b1;
    cpu('{26'h0800001, EBI_SZ_BYTE, EBI_KIND_OPND, 1'b0, 1'b1, 8'h00, 3'h4}, e);
    slow <= 1'b0;
    chk(e, exp_rd(26'h0800001, EBI_SZ_BYTE));
    ahb(1'b0, `EBI_STAT_IDX, 32'h0, d);
    chk({24'h0, d[15:8]}, 32'h5);
    $display("test external wait done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `EBI_MODE_IDX, 32'h0, d);
    chk(d, 32'h0);
    ahb(1'b0, `EBI_DWC_IDX, 32'h0, d);
    chk(d, 32'h7777);
    $display("test second reset done");
    wrap_up();
  end
endmodule : ebi_top_tb
